// >>> src/metering_dsp_register_slice.sv
// Purpose: Register slice of a polyphase metering DSP on Avalon-MM.
// Assumes: Measurement inputs are synchronous to i_clock.
// Notes: Byte address = 4 * register index; data in the low bits.
// How it works
// - Phase B and C fundamental rms read as 24 bits, zero padded to 32.
// - Word capture holds data of last good 32-bit transfer to an rms register.
// - Three 10-bit angle trims, read/write, reset zero, zero padded.
// - Line cycle count is 16-bit read/write, resets to all ones.
// - Computation setup is 16-bit read/write, resets to 0x01ff.
// - Pulse output setup is 16-bit read/write, resets to 0x0e88.
// - Power sign flags are read-only; writes have no effect.
// - Main setup is 16-bit read/write, resets to 0x0010.
// - Phase peak status is a 16-bit read-only word.
// - Three 16-bit read-only inter-phase delay registers.
// - Phase idle status is a 16-bit read-only word.
// - Byte capture holds data of last good 8-bit transfer.
`timescale 1ns/1ps
`default_nettype none
module metering_dsp_register_slice #(
  parameter int ADDR_W = 18
) (
  input wire logic i_clock, // 10 MHz clock
  input wire logic i_resetn, // Asynchronous reset, active low
  input wire logic [ADDR_W-1:0] i_address, // Avalon byte address
  input wire logic i_read, // Avalon read
  input wire logic i_write, // Avalon write
  input wire logic [31:0] i_writedata, // Avalon write data
  input wire logic [3:0] i_byteenable, // Avalon byte enables
  output logic [31:0] o_readdata, // Avalon read data
  output logic o_waitrequest, // Avalon wait request
  output logic [1:0] o_response, // Avalon read response
  input wire logic [23:0] i_b_fund_current_rms, // Phase B fund. I rms
  input wire logic [23:0] i_b_fund_voltage_rms, // Phase B fund. V rms
  input wire logic [23:0] i_c_fund_current_rms, // Phase C fund. I rms
  input wire logic [23:0] i_c_fund_voltage_rms, // Phase C fund. V rms
  input wire logic [15:0] i_phase_peak_status, // Peak phase flags
  input wire logic [15:0] i_phase_delay_first, // Delay 0
  input wire logic [15:0] i_phase_delay_second, // Delay 1
  input wire logic [15:0] i_phase_delay_third, // Delay 2
  input wire logic [15:0] i_phase_idle_status, // No-load flags
  input wire logic [15:0] i_power_sign_flags, // Power sign flags
  output logic [15:0] o_line_cycle_count, // Line cycle count
  output logic [15:0] o_zero_cross_timeout, // Zero-cross timeout
  output logic [15:0] o_computation_setup, // Computation mode
  output logic [15:0] o_pulse_output_setup, // Pulse output config
  output logic [15:0] o_pulse1_divisor, // Pulse 1 denominator
  output logic [15:0] o_pulse2_divisor, // Pulse 2 denominator
  output logic [15:0] o_pulse3_divisor, // Pulse 3 denominator
  output logic [9:0] o_phase_a_angle_trim, // Phase A calibration
  output logic [9:0] o_phase_b_angle_trim, // Phase B calibration
  output logic [9:0] o_phase_c_angle_trim, // Phase C calibration
  output logic [15:0] o_main_setup // Configuration word
);
  import meter_regs_pkg::*;

  // Decoded properties of one register index
  typedef struct packed {
    logic hit;
    logic rw;
    logic [1:0] size;
  } reg_info_t;

  // All software-writable state of the slice
  typedef struct packed {
    logic [15:0] line_cycle_count;
    logic [15:0] zero_cross_timeout;
    logic [15:0] computation_setup;
    logic [15:0] pulse_output_setup;
    logic [2:0][15:0] pulse_divisor;
    logic [2:0][9:0] angle_trim;
    logic [15:0] main_setup;
  } regs_t;

  localparam int N_PULSE = 3;

  logic [1:0] rst_sync_q;
  logic rst_n;
  regs_t q;
  regs_t d;
  reg_info_t info;
  logic [31:0] rdata;
  logic [15:0] wlow;

  reg_access_if acc ();

  ////////////////////////////////////////////////////////////////////////
  // Classify an index: mapped, writable, and transfer size class
  function automatic reg_info_t decode(input logic [15:0] idx);
    reg_info_t r;
    r = '{hit: 1'b1, rw: 1'b0, size: SZ_HALF};
    case (idx)
      IDX_B_FUND_CURRENT_RMS,
      IDX_B_FUND_VOLTAGE_RMS,
      IDX_C_FUND_CURRENT_RMS,
      IDX_C_FUND_VOLTAGE_RMS: r.size = SZ_WORD;
      IDX_LAST_WORD_CAPTURE,
      IDX_LAST_BYTE_CAPTURE: r.size = SZ_NONE; // Reading a capture keeps it
      IDX_PHASE_PEAK_STATUS,
      IDX_PHASE_DELAY_FIRST,
      IDX_PHASE_DELAY_SECOND,
      IDX_PHASE_DELAY_THIRD,
      IDX_PHASE_IDLE_STATUS,
      IDX_POWER_SIGN_FLAGS: r.rw = 1'b0;
      IDX_LINE_CYCLE_COUNT,
      IDX_ZERO_CROSS_TIMEOUT,
      IDX_COMPUTATION_SETUP,
      IDX_PULSE_OUTPUT_SETUP,
      IDX_PULSE1_DIVISOR,
      IDX_PULSE2_DIVISOR,
      IDX_PULSE3_DIVISOR,
      IDX_PHASE_A_ANGLE_TRIM,
      IDX_PHASE_B_ANGLE_TRIM,
      IDX_PHASE_C_ANGLE_TRIM,
      IDX_MAIN_SETUP: r.rw = 1'b1;
      default: r = '{hit: 1'b0, rw: 1'b0, size: SZ_NONE};
    endcase
    return r;
  endfunction : decode

  // Merge the two low byte lanes of a write into a 16-bit value
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [15:0] m;
    m = old;
    if (be[0])
      m[7:0] = wd[7:0];
    if (be[1])
      m[15:8] = wd[15:8];
    return m;
  endfunction : merge16

  ////////////////////////////////////////////////////////////////////////
  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////
  // Bus front end and transfer capture
  avalon_front #(
    .ADDR_W(ADDR_W)
  ) u_front (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .i_address(i_address),
    .i_read(i_read),
    .i_write(i_write),
    .i_writedata(i_writedata),
    .i_byteenable(i_byteenable),
    .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest),
    .o_response(o_response),
    .acc(acc.front)
  );

  xfer_capture u_capture (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .acc(acc.cap)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decode feeds the answer code and the capture size class
  assign info = decode(acc.idx);
  assign acc.hit = info.hit;
  assign acc.size = info.size;

  // Read multiplexer; narrow values sit low with zeros above
  always_comb
  begin
    rdata = 32'h0000_0000;
    case (acc.idx)
      IDX_B_FUND_CURRENT_RMS: rdata = {8'h00, i_b_fund_current_rms};
      IDX_B_FUND_VOLTAGE_RMS: rdata = {8'h00, i_b_fund_voltage_rms};
      IDX_C_FUND_CURRENT_RMS: rdata = {8'h00, i_c_fund_current_rms};
      IDX_C_FUND_VOLTAGE_RMS: rdata = {8'h00, i_c_fund_voltage_rms};
      IDX_LAST_WORD_CAPTURE: rdata = acc.word_cap;
      IDX_LAST_BYTE_CAPTURE: rdata = {24'h000000, acc.byte_cap};
      IDX_PHASE_PEAK_STATUS: rdata = {16'h0000, i_phase_peak_status};
      IDX_PHASE_DELAY_FIRST: rdata = {16'h0000, i_phase_delay_first};
      IDX_PHASE_DELAY_SECOND: rdata = {16'h0000, i_phase_delay_second};
      IDX_PHASE_DELAY_THIRD: rdata = {16'h0000, i_phase_delay_third};
      IDX_PHASE_IDLE_STATUS: rdata = {16'h0000, i_phase_idle_status};
      IDX_LINE_CYCLE_COUNT: rdata = {16'h0000, q.line_cycle_count};
      IDX_ZERO_CROSS_TIMEOUT: rdata = {16'h0000, q.zero_cross_timeout};
      IDX_COMPUTATION_SETUP: rdata = {16'h0000, q.computation_setup};
      IDX_PULSE_OUTPUT_SETUP: rdata = {16'h0000, q.pulse_output_setup};
      IDX_PULSE1_DIVISOR: rdata = {16'h0000, q.pulse_divisor[0]};
      IDX_PULSE2_DIVISOR: rdata = {16'h0000, q.pulse_divisor[1]};
      IDX_PULSE3_DIVISOR: rdata = {16'h0000, q.pulse_divisor[2]};
      IDX_PHASE_A_ANGLE_TRIM: rdata = {22'h000000, q.angle_trim[0]};
      IDX_PHASE_B_ANGLE_TRIM: rdata = {22'h000000, q.angle_trim[1]};
      IDX_PHASE_C_ANGLE_TRIM: rdata = {22'h000000, q.angle_trim[2]};
      IDX_POWER_SIGN_FLAGS: rdata = {16'h0000, i_power_sign_flags};
      IDX_MAIN_SETUP: rdata = {16'h0000, q.main_setup};
      default: rdata = 32'h0000_0000;
    endcase
  end

  assign acc.rdata = rdata;

  ////////////////////////////////////////////////////////////////////////
  // Write path. Only writable indices change state, so writes to
  // read-only or unassigned addresses fall through harmlessly.
  always_comb
  begin
    d = q;
    wlow = 16'h0000;
    if (acc.acc && acc.wr && info.rw)
    begin
      case (acc.idx)
        IDX_LINE_CYCLE_COUNT:
          d.line_cycle_count = merge16(q.line_cycle_count, acc.wdata, acc.be);
        IDX_ZERO_CROSS_TIMEOUT:
          d.zero_cross_timeout = merge16(q.zero_cross_timeout, acc.wdata, acc.be);
        IDX_COMPUTATION_SETUP:
          d.computation_setup = merge16(q.computation_setup, acc.wdata, acc.be);
        IDX_PULSE_OUTPUT_SETUP:
          d.pulse_output_setup = merge16(q.pulse_output_setup, acc.wdata, acc.be);
        IDX_PULSE1_DIVISOR:
          d.pulse_divisor[0] = merge16(q.pulse_divisor[0], acc.wdata, acc.be);
        IDX_PULSE2_DIVISOR:
          d.pulse_divisor[1] = merge16(q.pulse_divisor[1], acc.wdata, acc.be);
        IDX_PULSE3_DIVISOR:
          d.pulse_divisor[2] = merge16(q.pulse_divisor[2], acc.wdata, acc.be);
        IDX_PHASE_A_ANGLE_TRIM:
        begin
          wlow = merge16({6'h00, q.angle_trim[0]}, acc.wdata, acc.be);
          d.angle_trim[0] = wlow[TRIM_W-1:0];
        end
        IDX_PHASE_B_ANGLE_TRIM:
        begin
          wlow = merge16({6'h00, q.angle_trim[1]}, acc.wdata, acc.be);
          d.angle_trim[1] = wlow[TRIM_W-1:0];
        end
        IDX_PHASE_C_ANGLE_TRIM:
        begin
          wlow = merge16({6'h00, q.angle_trim[2]}, acc.wdata, acc.be);
          d.angle_trim[2] = wlow[TRIM_W-1:0];
        end
        IDX_MAIN_SETUP:
          d.main_setup = merge16(q.main_setup, acc.wdata, acc.be);
        default: d = q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register bank with documented reset values
  always_ff @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q.line_cycle_count <= RST_LINE_CYCLE_COUNT;
      q.zero_cross_timeout <= RST_ZERO_CROSS_TIMEOUT;
      q.computation_setup <= RST_COMPUTATION_SETUP;
      q.pulse_output_setup <= RST_PULSE_OUTPUT_SETUP;
      q.pulse_divisor <= {N_PULSE{RST_PULSE_DIVISOR}};
      q.angle_trim <= {N_PULSE{RST_ANGLE_TRIM}};
      q.main_setup <= RST_MAIN_SETUP;
    end
    else
      q <= d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Setup words drive the measurement engine straight from flops
  assign o_line_cycle_count = q.line_cycle_count;
  assign o_zero_cross_timeout = q.zero_cross_timeout;
  assign o_computation_setup = q.computation_setup;
  assign o_pulse_output_setup = q.pulse_output_setup;
  assign o_pulse1_divisor = q.pulse_divisor[0];
  assign o_pulse2_divisor = q.pulse_divisor[1];
  assign o_pulse3_divisor = q.pulse_divisor[2];
  assign o_phase_a_angle_trim = q.angle_trim[0];
  assign o_phase_b_angle_trim = q.angle_trim[1];
  assign o_phase_c_angle_trim = q.angle_trim[2];
  assign o_main_setup = q.main_setup;
endmodule : metering_dsp_register_slice
`default_nettype wire

// >>> src/meter_regs_pkg.sv
// Purpose: Shared constants for the metering register slice.
// Assumes: Register indices are word indices; byte address = 4 * index.
// Notes: Reset values and field widths live here only.
package meter_regs_pkg;
  // Bus geometry
  localparam int IDX_W = 16;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int HALF_W = 16;
  localparam int RMS_W = 24;
  localparam int TRIM_W = 10;
  localparam int BYTE_W = 8;
  // Register indices
  localparam logic [15:0] IDX_B_FUND_CURRENT_RMS = 16'he539;
  localparam logic [15:0] IDX_B_FUND_VOLTAGE_RMS = 16'he53a;
  localparam logic [15:0] IDX_C_FUND_CURRENT_RMS = 16'he53b;
  localparam logic [15:0] IDX_C_FUND_VOLTAGE_RMS = 16'he53c;
  localparam logic [15:0] IDX_LAST_WORD_CAPTURE = 16'he5ff;
  localparam logic [15:0] IDX_PHASE_PEAK_STATUS = 16'he600;
  localparam logic [15:0] IDX_PHASE_DELAY_FIRST = 16'he601;
  localparam logic [15:0] IDX_PHASE_DELAY_SECOND = 16'he602;
  localparam logic [15:0] IDX_PHASE_DELAY_THIRD = 16'he603;
  localparam logic [15:0] IDX_PHASE_IDLE_STATUS = 16'he608;
  localparam logic [15:0] IDX_LINE_CYCLE_COUNT = 16'he60c;
  localparam logic [15:0] IDX_ZERO_CROSS_TIMEOUT = 16'he60d;
  localparam logic [15:0] IDX_COMPUTATION_SETUP = 16'he60e;
  localparam logic [15:0] IDX_PULSE_OUTPUT_SETUP = 16'he610;
  localparam logic [15:0] IDX_PULSE1_DIVISOR = 16'he611;
  localparam logic [15:0] IDX_PULSE2_DIVISOR = 16'he612;
  localparam logic [15:0] IDX_PULSE3_DIVISOR = 16'he613;
  localparam logic [15:0] IDX_PHASE_A_ANGLE_TRIM = 16'he614;
  localparam logic [15:0] IDX_PHASE_B_ANGLE_TRIM = 16'he615;
  localparam logic [15:0] IDX_PHASE_C_ANGLE_TRIM = 16'he616;
  localparam logic [15:0] IDX_POWER_SIGN_FLAGS = 16'he617;
  localparam logic [15:0] IDX_MAIN_SETUP = 16'he618;
  localparam logic [15:0] IDX_LAST_BYTE_CAPTURE = 16'he7fd;
  // Reset values
  localparam logic [15:0] RST_LINE_CYCLE_COUNT = 16'hffff;
  localparam logic [15:0] RST_ZERO_CROSS_TIMEOUT = 16'hffff;
  localparam logic [15:0] RST_COMPUTATION_SETUP = 16'h01ff;
  localparam logic [15:0] RST_PULSE_OUTPUT_SETUP = 16'h0e88;
  localparam logic [15:0] RST_PULSE_DIVISOR = 16'h0000;
  localparam logic [9:0] RST_ANGLE_TRIM = 10'h000;
  localparam logic [15:0] RST_MAIN_SETUP = 16'h0010;
  // Transfer size classes, used by the capture logic
  localparam logic [1:0] SZ_NONE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [3:0] BE_ALL = 4'hf;
  localparam logic [3:0] BE_LOW = 4'h1;
  // Avalon response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECODE_ERR = 2'h3;
endpackage : meter_regs_pkg

// >>> src/reg_access_if.sv
// Purpose: Internal access path between bus front, registers and capture.
// Assumes: acc is a one-cycle strobe, all others are valid with it.
// Notes: rdata, hit and size are combinational from the register file.
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if;
  logic acc;
  logic wr;
  logic [15:0] idx;
  logic [31:0] wdata;
  logic [3:0] be;
  logic [31:0] rdata;
  logic hit;
  logic [1:0] size;
  logic [31:0] word_cap;
  logic [7:0] byte_cap;
  modport front (output acc, wr, idx, wdata, be, input rdata, hit);
  modport regs (input acc, wr, idx, wdata, be, word_cap, byte_cap,
    output rdata, hit, size);
  modport cap (input acc, wr, wdata, rdata, be, size, output word_cap, byte_cap);
endinterface : reg_access_if
`default_nettype wire

// >>> src/avalon_front.sv
// Purpose: Avalon-MM slave front end with one wait state.
// Assumes: Master holds the request until it sees waitrequest low.
// Notes: Access strobe fires in the first cycle; answer one cycle later.
`timescale 1ns/1ps
`default_nettype none
module avalon_front #(
  parameter int ADDR_W = 18
) (
  input wire logic i_clock, // System clock
  input wire logic i_rst_n, // Synchronised reset, active low
  input wire logic [ADDR_W-1:0] i_address, // Byte address
  input wire logic i_read, // Read request
  input wire logic i_write, // Write request
  input wire logic [31:0] i_writedata, // Write data
  input wire logic [3:0] i_byteenable, // Byte lanes
  output logic [31:0] o_readdata, // Read data
  output logic o_waitrequest, // Stall
  output logic [1:0] o_response, // Read response code
  reg_access_if.front acc // Internal access path
);
  import meter_regs_pkg::*;

  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_ACK = 2'b10} front_state_t;
  typedef struct packed {
    front_state_t st;
    logic [31:0] rdata;
    logic [1:0] resp;
  } front_t;

  front_t q;
  front_t d;

  // Index must fill the word address exactly
  if (ADDR_W != IDX_W + 2)
  begin : g_chk
    $error("avalon_front: ADDR_W must equal IDX_W + 2");
  end

  ////////////////////////////////////////////////////////////////////////
  // Strobe only in idle, so a held request is taken exactly once
  assign acc.acc = (q.st == ST_IDLE) && (i_read || i_write);
  assign acc.wr = i_write;
  assign acc.idx = i_address[ADDR_W-1:2];
  assign acc.wdata = i_writedata;
  assign acc.be = i_byteenable;

  // Next state and captured answer
  always_comb
  begin
    d = q;
    case (q.st)
      ST_IDLE:
      begin
        if (i_read || i_write)
        begin
          d.st = ST_ACK;
          d.rdata = i_write ? 32'h0000_0000 : acc.rdata;
          d.resp = acc.hit ? RESP_OKAY : RESP_DECODE_ERR;
        end
      end
      ST_ACK: d.st = ST_IDLE;
      default: d.st = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      q <= '{st: ST_IDLE, rdata: 32'h0000_0000, resp: RESP_OKAY};
    else
      q <= d;
  end

  assign o_waitrequest = (q.st != ST_ACK);
  assign o_readdata = q.rdata;
  assign o_response = q.resp;
endmodule : avalon_front
`default_nettype wire

// >>> src/xfer_capture.sv
// Purpose: Holds the data of the last successful word and byte transfers.
// Assumes: size is SZ_NONE for unmapped and capture registers.
// Notes: A byte transfer is a mapped access with only lane 0 enabled.
`timescale 1ns/1ps
`default_nettype none
module xfer_capture (
  input wire logic i_clock, // System clock
  input wire logic i_rst_n, // Synchronised reset, active low
  reg_access_if.cap acc // Internal access path
);
  import meter_regs_pkg::*;

  typedef struct packed {
    logic [31:0] word;
    logic [7:0] bytev;
  } cap_t;

  cap_t q;
  cap_t d;
  logic [31:0] data;

  ////////////////////////////////////////////////////////////////////////
  // Data of a transfer is what actually crossed the bus
  assign data = acc.wr ? acc.wdata : acc.rdata;

  // Only complete, mapped transfers update; errors leave captures alone
  always_comb
  begin
    d = q;
    if (acc.acc && acc.size == SZ_WORD && acc.be == BE_ALL)
      d.word = data;
    if (acc.acc && acc.size != SZ_NONE && acc.be == BE_LOW)
      d.bytev = data[7:0];
  end

  // Capture registers
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      q <= '{word: 32'h0000_0000, bytev: 8'h00};
    else
      q <= d;
  end

  assign acc.word_cap = q.word;
  assign acc.byte_cap = q.bytev;
endmodule : xfer_capture
`default_nettype wire

// >>> test/slice_asserts.sv
// Purpose: Bus timing and register checks at the slice ports.
// Assumes: Register index is address bits 17 to 2.
// Notes: A request is taken only while waitrequest is high.
`timescale 1ns/1ps
`default_nettype none
module slice_asserts #(
  parameter int ADDR_W = 18
) (
  input wire logic i_clock, // Clock
  input wire logic i_resetn, // Reset, active low
  input wire logic [ADDR_W-1:0] i_address, // Byte address
  input wire logic i_read, // Read
  input wire logic i_write, // Write
  input wire logic [31:0] i_writedata, // Write data
  input wire logic [3:0] i_byteenable, // Lanes
  input wire logic [31:0] o_readdata, // Read data
  input wire logic o_waitrequest, // Stall
  input wire logic [1:0] o_response, // Response
  input wire logic [23:0] i_b_fund_current_rms, // Phase B current rms
  input wire logic [15:0] i_power_sign_flags, // Sign flags
  input wire logic [15:0] o_line_cycle_count, // Line cycles
  input wire logic [15:0] o_computation_setup, // Computation mode
  input wire logic [15:0] o_pulse_output_setup, // Pulse setup
  input wire logic [15:0] o_main_setup // Main setup
);
  import meter_regs_pkg::*;
  logic [15:0] idx;
  logic ans;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  // Index and answer strobe, so each property reads short
  assign idx = i_address[ADDR_W-1:2];
  assign ans = !o_waitrequest;
  one_wait_a: assert property ((i_read || i_write) && o_waitrequest |=> ans)
    else $error("Answer did not follow one wait state");
  short_answer_a: assert property (ans |=> !ans)
    else $error("Waitrequest low for more than one cycle");
  rms_pad_a: assert property (
    ans && $past(i_read) && $past(idx) == IDX_B_FUND_CURRENT_RMS
    |-> o_readdata == {8'h00, $past(i_b_fund_current_rms)}) else $error("Rms read wrong");
  sign_read_a: assert property (
    ans && $past(i_read) && $past(idx) == IDX_POWER_SIGN_FLAGS
    |-> o_readdata == {16'h0000, $past(i_power_sign_flags)}) else $error("Sign read wrong");
  trim_pad_a: assert property (
    ans && $past(i_read) && $past(idx) inside {[16'he614:16'he616]}
    |-> o_readdata[31:10] == 22'h0) else $error("Trim read not zero padded");
  line_write_a: assert property (
    i_write && o_waitrequest && idx == IDX_LINE_CYCLE_COUNT && i_byteenable == 4'hf
    |=> o_line_cycle_count == $past(i_writedata[15:0])) else $error("Line count not written");
  reset_vals_a: assert property ($rose(i_resetn) |-> o_main_setup == 16'h0010 &&
    o_computation_setup == 16'h01ff && o_pulse_output_setup == 16'h0e88)
    else $error("Setup reset value wrong");
  main_hold_a: assert property (
    !$stable(o_main_setup) |-> $past(i_write) && $past(idx) == IDX_MAIN_SETUP)
    else $error("Main setup changed without a write");
  unmapped_a: assert property (
    ans && $past(idx) == 16'he53d |-> o_response == RESP_DECODE_ERR)
    else $error("Unassigned access not refused");
endmodule : slice_asserts
`default_nettype wire

// >>> test/host_model.sv
// Purpose: Host side of the register bus, an Avalon-MM master.
// Assumes: xfer is entered right after a rising clock edge.
// Notes: No wait limit here; the bench watchdog cuts a hang.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic i_clock, // Clock
  input wire logic i_waitrequest, // Slave stall
  input wire logic [31:0] i_readdata, // Read data
  input wire logic [1:0] i_response, // Response code
  output logic [17:0] o_address, // Byte address
  output logic o_read, // Read request
  output logic o_write, // Write request
  output logic [31:0] o_writedata, // Write data
  output logic [3:0] o_byteenable // Byte lanes
);
  initial {o_address, o_read, o_write, o_writedata, o_byteenable} = '0;
  // One transfer, held whole until waitrequest is sampled low
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] wd,
    input logic [3:0] be, output logic [31:0] rd, output logic [1:0] rs);
    o_read <= !w;
    o_write <= w;
    o_address <= {idx, 2'b00};
    o_writedata <= wd;
    o_byteenable <= be;
    do @(posedge i_clock); while (i_waitrequest !== 1'b0);
    rd = i_readdata;
    rs = i_response;
    o_read <= 1'b0;
    o_write <= 1'b0;
    o_writedata <= ~wd; // Released data must not look valid
    @(posedge i_clock);
  endtask : xfer
endmodule : host_model
`default_nettype wire

// >>> test/metering_dsp_register_slice_test.sv
// Purpose: Self-checking bench for the metering register slice.
// Assumes: Host model owns the bus; bench owns measurement inputs.
// Notes: Expected values come from the register table only.
`timescale 1ns/1ps
`default_nettype none
module metering_dsp_register_slice_test;
  import meter_regs_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [17:0] address;
  logic bus_rd;
  logic bus_wr;
  logic [31:0] writedata;
  logic [3:0] byteenable;
  logic [31:0] readdata;
  logic waitrequest;
  logic [1:0] response;
  logic [15:0] so [8];
  logic [9:0] tr [3];
  logic [23:0] rms [4] = '{default: 24'h0};
  logic [15:0] ro16 [6] = '{default: 16'h0};
  logic [31:0] rdata;
  logic [1:0] resp;
  int n_errors = 0;
  int checks_done = 0;
  logic [15:0] rw_idx [11] = '{16'he60c, 16'he60d, 16'he60e, 16'he610, 16'he611, 16'he612,
    16'he613, 16'he614, 16'he615, 16'he616, 16'he618};
  logic [15:0] rw_rst [11] = '{16'hffff, 16'hffff, 16'h01ff, 16'h0e88, 16'h0, 16'h0, 16'h0,
    16'h0, 16'h0, 16'h0, 16'h0010};
  logic [15:0] ro_idx [6] = '{16'he600, 16'he601, 16'he602, 16'he603, 16'he608, 16'he617};
  // 10 MHz clock
  always #50 clock = ~clock;
  host_model host_model_i (.i_clock(clock), .i_waitrequest(waitrequest), .i_readdata(readdata),
    .i_response(response), .o_address(address), .o_read(bus_rd), .o_write(bus_wr),
    .o_writedata(writedata), .o_byteenable(byteenable));
  metering_dsp_register_slice metering_dsp_register_slice_i (
    .i_clock(clock), .i_resetn(resetn), .i_address(address), .i_read(bus_rd),
    .i_write(bus_wr), .i_writedata(writedata), .i_byteenable(byteenable),
    .o_readdata(readdata), .o_waitrequest(waitrequest), .o_response(response),
    .i_b_fund_current_rms(rms[0]), .i_b_fund_voltage_rms(rms[1]),
    .i_c_fund_current_rms(rms[2]), .i_c_fund_voltage_rms(rms[3]),
    .i_phase_peak_status(ro16[0]), .i_phase_delay_first(ro16[1]),
    .i_phase_delay_second(ro16[2]), .i_phase_delay_third(ro16[3]),
    .i_phase_idle_status(ro16[4]), .i_power_sign_flags(ro16[5]),
    .o_line_cycle_count(so[0]), .o_zero_cross_timeout(so[1]), .o_computation_setup(so[2]),
    .o_pulse_output_setup(so[3]), .o_pulse1_divisor(so[4]), .o_pulse2_divisor(so[5]),
    .o_pulse3_divisor(so[6]), .o_phase_a_angle_trim(tr[0]), .o_phase_b_angle_trim(tr[1]),
    .o_phase_c_angle_trim(tr[2]), .o_main_setup(so[7]));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [15:0] idx, input logic [31:0] wd,
    input logic [3:0] be);
    host_model_i.xfer(w, idx, wd, be, rdata, resp);
  endtask : acc
  // Every setup word must read its reset value first
  task automatic t_reset;
    for (int k = 0; k < 11; k++)
    begin
      acc(1'b0, rw_idx[k], 32'h0, 4'hf);
      chk("reset value", {16'h0, rw_rst[k]}, rdata);
    end
  endtask : t_reset
  // All-ones high half shows the zero padding; trims keep 10 bits
  task automatic t_rw;
    logic [31:0] mask;
    logic [15:0] seen;
    for (int k = 0; k < 11; k++)
    begin
      mask = (k > 6 && k < 10) ? 32'h3ff : 32'hffff;
      acc(1'b1, rw_idx[k], 32'hffff_c3a0 + k, 4'hf);
      acc(1'b0, rw_idx[k], 32'h0, 4'hf);
      chk("readback", (32'hffff_c3a0 + k) & mask, rdata);
      // Each setup word must also reach its output port
      seen = k < 7 ? so[k] : k > 9 ? so[7] : {6'h0, tr[k-7]};
      chk("setup port", (32'hffff_c3a0 + k) & mask, {16'h0, seen});
    end
    chk("main setup port", 32'hc3aa, {16'h0, so[7]});
  endtask : t_rw
  // Live results read back padded; a write to the sign word is ignored
  task automatic t_ro;
    for (int k = 0; k < 6; k++)
    begin
      if (k < 4)
        rms[k] <= 24'(24'h8abc00 + k);
      ro16[k] <= 16'(16'h9c00 + k);
    end
    for (int k = 0; k < 4; k++)
    begin
      acc(1'b0, 16'(16'he539 + k), 32'h0, 4'hf);
      chk("rms read", 32'h008abc00 + k, rdata);
    end
    acc(1'b1, 16'he617, 32'h0, 4'hf);
    for (int k = 0; k < 6; k++)
    begin
      acc(1'b0, ro_idx[k], 32'h0, 4'hf);
      chk("status read", 32'h9c00 + k, rdata);
      chk("status response", 32'h0, {30'h0, resp});
    end
  endtask : t_ro
  // Captures follow good transfers only; unassigned places are only read
  task automatic t_capture;
    acc(1'b0, 16'he53a, 32'h0, 4'hf);
    acc(1'b0, 16'he5ff, 32'h0, 4'hf);
    chk("word capture read", 32'h008abc01, rdata);
    acc(1'b1, 16'he53b, 32'h1234_5678, 4'hf);
    acc(1'b0, 16'he53d, 32'h0, 4'hf);
    chk("unassigned response", 32'h3, {30'h0, resp});
    acc(1'b0, 16'he5ff, 32'h0, 4'hf);
    chk("word capture write", 32'h1234_5678, rdata);
    acc(1'b1, 16'he618, 32'h0000_005a, 4'h1);
    acc(1'b0, 16'he7fd, 32'h0, 4'hf);
    chk("byte capture", 32'h5a, rdata);
  endtask : t_capture
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  // Main sequence: reset for 20 cycles, then the scenarios
  initial
  begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    t_reset();
    t_rw();
    t_ro();
    t_capture();
    summarize();
  end
  // Watchdog, well beyond the 180 or so cycles the run needs
  initial
  begin
    repeat (5000) @(posedge clock);
    n_errors++;
    summarize();
  end
endmodule : metering_dsp_register_slice_test
bind metering_dsp_register_slice slice_asserts #(.ADDR_W(ADDR_W)) slice_asserts_i (.*);
`default_nettype wire
